// File: rtl/debug_port_pkg.sv
/*
 * constants, codes and state type for the two-wire debug and flash port.
 * assumes a single 100 MHz core clock with synchronous active-high reset.
 */
// How it works
// - two lines: host clock, turnaround data line
// - select register picks data read/write target
// - select 0x00 reads part identity
// - select 0x01 reads silicon revision
// - select 0x02 reads/writes flash control
// - select 0xAD reads/writes flash data
// - identity is fixed, 8-bit, writes ignored
// - flash commands/addresses/data pass through data register
// - decode 0x06, 0x07, 0x08, 0x03 commands
// - clock on reset pin, data on port pin
package debug_port_pkg;
   localparam int BYTE_W = 8;
   localparam int INSTR_W = 2;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_INSTR_LAST = 3'h1;
   localparam logic [CNT_W-1:0] CNT_BYTE_LAST = 3'h7;
   localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;

   // instruction codes, sent least significant bit first
   localparam logic [INSTR_W-1:0] INSTR_DATA_READ = 2'h0;
   localparam logic [INSTR_W-1:0] INSTR_DATA_WRITE = 2'h1;
   localparam logic [INSTR_W-1:0] INSTR_ADDR_READ = 2'h2;
   localparam logic [INSTR_W-1:0] INSTR_ADDR_WRITE = 2'h3;

   // data register targets
   localparam logic [BYTE_W-1:0] SEL_PART_IDENTITY = 8'h00;
   localparam logic [BYTE_W-1:0] SEL_SILICON_REVISION = 8'h01;
   localparam logic [BYTE_W-1:0] SEL_FLASH_CONTROL = 8'h02;
   localparam logic [BYTE_W-1:0] SEL_FLASH_DATA = 8'hAD;

   // flash command codes
   localparam logic [BYTE_W-1:0] CMD_BLOCK_READ = 8'h06;
   localparam logic [BYTE_W-1:0] CMD_BLOCK_WRITE = 8'h07;
   localparam logic [BYTE_W-1:0] CMD_PAGE_ERASE = 8'h08;
   localparam logic [BYTE_W-1:0] CMD_DEVICE_ERASE = 8'h03;

   // reset values
   localparam logic [BYTE_W-1:0] SELECT_RESET = 8'h00;
   localparam logic [BYTE_W-1:0] CONTROL_RESET = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [INSTR_W-1:0] INSTR_RESET = 2'h0;

   // identity values; both defaults are arbitrary neutral values
   localparam logic [BYTE_W-1:0] PART_IDENTITY_DEFAULT = 8'h5A;
   localparam logic [BYTE_W-1:0] SILICON_REVISION_DEFAULT = 8'h01;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_INSTR = 3'b001,
      ST_DATA_IN = 3'b010,
      ST_DATA_OUT = 3'b011,
      ST_STOP = 3'b100
   } state_type;
endpackage

// File: rtl/two_wire_debug_flash_port.sv
/*
 * device end of the two-wire debug and flash programming port.
 * assumes the host toggles the link clock slowly against clk (period >= 8 clk),
 * and that the flash controller beside it answers on the same clk.
 */
`timescale 1ns/100ps
module two_wire_debug_flash_port (
   input wire logic clk, // core clock, 100 MHz
   input wire logic srst, // synchronous reset
   input wire logic debug_link_clock, // reset pin, host-driven link clock
   input wire logic port_three_bit_zero_pin_in, // shared data pin level
   output logic port_three_bit_zero_pin_out, // shared data pin drive value
   output logic port_three_bit_zero_pin_oe, // shared data pin drive enable
   input wire logic user_pin_out, // user logic drive value
   input wire logic user_pin_oe, // user logic drive enable
   input wire logic [debug_port_pkg::BYTE_W-1:0] fpd_read_value, // flash side byte
   output logic fpd_read_strobe, // flash data byte taken by host
   output logic fpd_write_strobe, // flash data byte written
   output logic [debug_port_pkg::BYTE_W-1:0] fpd_write_data, // written byte
   output logic cmd_valid, // recognised flash command
   output logic [debug_port_pkg::BYTE_W-1:0] cmd_code, // its code
   output logic arg_valid, // byte belongs to running command
   input wire logic flash_done, // flash command finished
   output logic cmd_active, // a flash command is running
   output logic [debug_port_pkg::BYTE_W-1:0] flash_program_control, // control register
   output logic frame_active // link frame in progress
);
   import debug_port_pkg::*;

   logic ck_meta_reg, ck_sync_reg, ck_prev_reg;
   logic d_meta_reg, d_sync_reg;
   state_type state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [INSTR_W-1:0] instr_reg, instr_next;
   logic [BYTE_W-1:0] shift_reg, shift_next;
   logic [BYTE_W-1:0] select_reg;
   logic [BYTE_W-1:0] control_reg;
   logic [BYTE_W-1:0] fpd_data_reg;
   logic fpd_write_reg, cmd_valid_reg, arg_valid_reg, cmd_active_reg;
   logic [BYTE_W-1:0] cmd_code_reg;

   // link clock and data pass two flops before use
   always_ff @(posedge clk) begin
      if (srst) begin
         ck_meta_reg <= 1'b1;
         ck_sync_reg <= 1'b1;
         ck_prev_reg <= 1'b1;
         d_meta_reg <= 1'b0;
         d_sync_reg <= 1'b0;
      end else begin
         ck_meta_reg <= debug_link_clock;
         ck_sync_reg <= ck_meta_reg;
         ck_prev_reg <= ck_sync_reg;
         d_meta_reg <= port_three_bit_zero_pin_in;
         d_sync_reg <= d_meta_reg;
      end
   end

   wire ck_rise = ck_sync_reg && !ck_prev_reg;
   wire [INSTR_W-1:0] instr_full = {d_sync_reg, instr_reg[1]};
   wire [BYTE_W-1:0] byte_full = {d_sync_reg, shift_reg[7:1]};
   wire instr_done = (state_reg == ST_INSTR) && ck_rise && (cnt_reg == CNT_INSTR_LAST);
   wire is_write_instr = instr_full[0];
   wire is_addr_instr = instr_full[1];
   wire load_read = instr_done && !is_write_instr;
   wire commit = (state_reg == ST_DATA_IN) && ck_rise && (cnt_reg == CNT_BYTE_LAST);
   wire commit_addr = commit && instr_reg[1];
   wire commit_data = commit && !instr_reg[1];
   wire wr_control = commit_data && (select_reg == SEL_FLASH_CONTROL);
   wire wr_fpd = commit_data && (select_reg == SEL_FLASH_DATA);
   wire cmd_known = (byte_full == CMD_BLOCK_READ) || (byte_full == CMD_BLOCK_WRITE) ||
      (byte_full == CMD_PAGE_ERASE) || (byte_full == CMD_DEVICE_ERASE);

   // read target chosen by select; unmapped targets read as zero
   wire [BYTE_W-1:0] data_read_value =
      (select_reg == SEL_PART_IDENTITY) ? PART_IDENTITY_DEFAULT :
      (select_reg == SEL_SILICON_REVISION) ? SILICON_REVISION_DEFAULT :
      (select_reg == SEL_FLASH_CONTROL) ? control_reg :
      (select_reg == SEL_FLASH_DATA) ? fpd_read_value : BYTE_ZERO;
   wire [BYTE_W-1:0] read_value = is_addr_instr ? select_reg : data_read_value;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      instr_next = instr_reg;
      shift_next = shift_reg;
      case (state_reg)
         ST_IDLE: begin
            if (ck_rise) begin
               state_next = ST_INSTR;
               cnt_next = CNT_RESET;
            end
         end
         ST_INSTR: begin
            if (ck_rise) begin
               instr_next = instr_full;
               cnt_next = cnt_reg + 3'h1;
               if (cnt_reg == CNT_INSTR_LAST) begin
                  cnt_next = CNT_RESET;
                  state_next = is_write_instr ? ST_DATA_IN : ST_DATA_OUT;
                  shift_next = is_write_instr ? shift_reg : read_value;
               end
            end
         end
         ST_DATA_IN: begin
            if (ck_rise) begin
               shift_next = byte_full;
               cnt_next = cnt_reg + 3'h1;
               if (cnt_reg == CNT_BYTE_LAST) begin
                  state_next = ST_STOP;
               end
            end
         end
         ST_DATA_OUT: begin
            // host samples each bit on the rising edge, so shift after it
            if (ck_rise) begin
               shift_next = {1'b0, shift_reg[7:1]};
               cnt_next = cnt_reg + 3'h1;
               if (cnt_reg == CNT_BYTE_LAST) begin
                  state_next = ST_STOP;
               end
            end
         end
         ST_STOP: begin
            if (ck_rise) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= CNT_RESET;
         instr_reg <= INSTR_RESET;
         shift_reg <= BYTE_ZERO;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         instr_reg <= instr_next;
         shift_reg <= shift_next;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         select_reg <= SELECT_RESET;
         control_reg <= CONTROL_RESET;
      end else begin
         if (commit_addr) begin
            select_reg <= byte_full;
         end
         if (wr_control) begin
            control_reg <= byte_full;
         end
      end
   end

   // a command opens a run of argument bytes until the flash side reports done;
   // an unknown code while no command runs is passed on as a data byte but starts no command
   always_ff @(posedge clk) begin
      if (srst) begin
         fpd_write_reg <= 1'b0;
         fpd_data_reg <= BYTE_ZERO;
         cmd_valid_reg <= 1'b0;
         arg_valid_reg <= 1'b0;
         cmd_code_reg <= BYTE_ZERO;
         cmd_active_reg <= 1'b0;
      end else begin
         fpd_write_reg <= wr_fpd;
         cmd_valid_reg <= wr_fpd && !cmd_active_reg && cmd_known;
         arg_valid_reg <= wr_fpd && cmd_active_reg;
         if (wr_fpd) begin
            fpd_data_reg <= byte_full;
         end
         if (wr_fpd && !cmd_active_reg && cmd_known) begin
            cmd_code_reg <= byte_full;
            cmd_active_reg <= 1'b1;
         end else if (flash_done) begin
            cmd_active_reg <= 1'b0;
         end
      end
   end

   // the link owns the pin only while shifting out; user drive otherwise,
   // which the host must keep frozen while the device is halted
   wire link_drive = (state_reg == ST_DATA_OUT);
   assign port_three_bit_zero_pin_oe = link_drive ? 1'b1 : user_pin_oe;
   assign port_three_bit_zero_pin_out = link_drive ? shift_reg[0] : user_pin_out;
   assign fpd_read_strobe = load_read && !is_addr_instr && (select_reg == SEL_FLASH_DATA);
   assign fpd_write_strobe = fpd_write_reg;
   assign fpd_write_data = fpd_data_reg;
   assign cmd_valid = cmd_valid_reg;
   assign cmd_code = cmd_code_reg;
   assign arg_valid = arg_valid_reg;
   assign cmd_active = cmd_active_reg;
   assign flash_program_control = control_reg;
   assign frame_active = (state_reg != ST_IDLE);

   sequence s_commit_fpd;
      commit_data ##0 (select_reg == SEL_FLASH_DATA);
   endsequence

   sequence s_load_sel(logic [BYTE_W-1:0] sel);
      load_read && !is_addr_instr && (select_reg == sel);
   endsequence

   a_identity_read: assert property (@(posedge clk) disable iff (srst)
      s_load_sel(SEL_PART_IDENTITY) |=> (shift_reg == PART_IDENTITY_DEFAULT))
      else $error("identity read returned wrong byte");
   a_revision_read: assert property (@(posedge clk) disable iff (srst)
      s_load_sel(SEL_SILICON_REVISION) |=> (shift_reg == SILICON_REVISION_DEFAULT))
      else $error("revision read returned wrong byte");
   a_control_write: assert property (@(posedge clk) disable iff (srst)
      wr_control |=> (flash_program_control == $past(byte_full)))
      else $error("control write not stored");
   a_fpd_write: assert property (@(posedge clk) disable iff (srst)
      s_commit_fpd |=> fpd_write_strobe && (fpd_write_data == $past(byte_full)))
      else $error("flash data write not passed on");
   a_identity_fixed: assert property (@(posedge clk) disable iff (srst)
      (commit_data && select_reg == SEL_PART_IDENTITY) |=> $stable(flash_program_control))
      else $error("identity write changed state");
   a_cmd_decode: assert property (@(posedge clk) disable iff (srst)
      (wr_fpd && !cmd_active_reg && byte_full == CMD_PAGE_ERASE) |=>
      cmd_valid && (cmd_code == CMD_PAGE_ERASE) && cmd_active ##1 !cmd_valid)
      else $error("page erase not decoded");
   a_arg_pass: assert property (@(posedge clk) disable iff (srst)
      (wr_fpd && cmd_active_reg) |=> arg_valid && !cmd_valid)
      else $error("argument byte not marked");
   a_select_hold: assert property (@(posedge clk) disable iff (srst)
      !commit_addr |=> $stable(select_reg))
      else $error("select changed without address write");
   a_read_drive: assert property (@(posedge clk) disable iff (srst)
      load_read |=> port_three_bit_zero_pin_oe [*8])
      else $error("data line not driven during read");
   a_pin_share: assert property (@(posedge clk) disable iff (srst)
      (state_reg != ST_DATA_OUT) |->
      (port_three_bit_zero_pin_oe == user_pin_oe) && (port_three_bit_zero_pin_out == user_pin_out))
      else $error("user pin drive not passed through");

   // read mux: every target must reach the shift register unchanged
   sequence s_out_rise;
      (state_reg == ST_DATA_OUT) && ck_rise;
   endsequence

   a_control_read: assert property (@(posedge clk) disable iff (srst)
      s_load_sel(SEL_FLASH_CONTROL) |=> (shift_reg == $past(control_reg)))
      else $error("control read returned wrong byte");
   a_fpd_read: assert property (@(posedge clk) disable iff (srst)
      s_load_sel(SEL_FLASH_DATA) |->
      fpd_read_strobe ##1 (shift_reg == $past(fpd_read_value)))
      else $error("flash data read not loaded");
   a_addr_read: assert property (@(posedge clk) disable iff (srst)
      (load_read && is_addr_instr) |=> (shift_reg == $past(select_reg)))
      else $error("address read returned wrong byte");
   a_unmapped_read: assert property (@(posedge clk) disable iff (srst)
      (load_read && !is_addr_instr && (select_reg != SEL_PART_IDENTITY) &&
      (select_reg != SEL_SILICON_REVISION) && (select_reg != SEL_FLASH_CONTROL) &&
      (select_reg != SEL_FLASH_DATA)) |=> (shift_reg == BYTE_ZERO))
      else $error("unmapped read not zero");

   // write side: only the selected target may move
   a_select_write: assert property (@(posedge clk) disable iff (srst)
      commit_addr |=> (select_reg == $past(byte_full)))
      else $error("address write not stored");
   a_control_hold: assert property (@(posedge clk) disable iff (srst)
      !wr_control |=> $stable(flash_program_control))
      else $error("control changed without write");
   a_fpd_target: assert property (@(posedge clk) disable iff (srst)
      (commit_data && (select_reg != SEL_FLASH_DATA)) |=> !fpd_write_strobe)
      else $error("flash data strobe for other target");
   a_strobe_single: assert property (@(posedge clk) disable iff (srst)
      fpd_write_strobe |=> !fpd_write_strobe)
      else $error("flash data strobe longer than one cycle");

   // command bookkeeping; a new command beats flash done in the same cycle
   a_unknown_cmd: assert property (@(posedge clk) disable iff (srst)
      (wr_fpd && !cmd_active_reg && !cmd_known) |=>
      fpd_write_strobe && !cmd_valid && !cmd_active)
      else $error("unknown code started a command");
   a_cmd_end: assert property (@(posedge clk) disable iff (srst)
      (flash_done && !wr_fpd) |=> !cmd_active)
      else $error("command not ended by flash done");
   a_code_hold: assert property (@(posedge clk) disable iff (srst)
      !(wr_fpd && !cmd_active_reg && cmd_known) |=> $stable(cmd_code))
      else $error("command code changed without command");

   // pin follows the shift register one clk after each seen rise but the last, after which the pin returns to the user drive
   a_bit_shift: assert property (@(posedge clk) disable iff (srst)
      s_out_rise ##0 (cnt_reg != CNT_BYTE_LAST) |=>
      port_three_bit_zero_pin_oe && (port_three_bit_zero_pin_out == $past(shift_reg[1])))
      else $error("read bit not advanced");
   a_read_release: assert property (@(posedge clk) disable iff (srst)
      s_out_rise ##0 (cnt_reg == CNT_BYTE_LAST) |=>
      (port_three_bit_zero_pin_oe == user_pin_oe))
      else $error("data line not released after read");
   a_frame_open: assert property (@(posedge clk) disable iff (srst)
      ((state_reg == ST_IDLE) && ck_rise) |=> frame_active)
      else $error("frame not opened on first edge");
   a_frame_close: assert property (@(posedge clk) disable iff (srst)
      ((state_reg == ST_STOP) && ck_rise) |=> !frame_active)
      else $error("frame not closed after stop bit");
endmodule

// File: verification/host_adapter_model.sv
/*
 * behavioural host adapter for the two-wire debug link: drives the link clock
 * and the data line, and resolves the shared data wire.
 * assumes the user drive on the data pin stays frozen while frames run.
 */
`timescale 1ns/100ps
module host_adapter_model (
   input wire logic dev_out, // device drive value on the data pin
   input wire logic dev_oe, // device drive enable
   output logic link_clock, // host link clock, idle high
   output logic pin_level // resolved data wire level
);
   localparam time HALF = 80ns;
   logic host_oe = 1'b0;
   logic host_val = 1'b0;
   logic [7:0] rd_value;
   event rd_ev;
   // the reset pin carries only the host clock here, never a user drive
   initial link_clock = 1'b1;
   initial pin_level = 1'b0;
   // host beats the user drive through isolation resistors; a released wire shows
   // the inverse of its last level so a missing device drive cannot pass
   always @(host_oe, host_val, dev_oe, dev_out) begin
      if (host_oe) pin_level = host_val;
      else if (dev_oe) pin_level = dev_out;
      else pin_level = ~pin_level;
   end
   task bit_cycle(input logic drv, input logic val);
      link_clock = 1'b0;
      host_oe = drv;
      host_val = val;
      #HALF;
      link_clock = 1'b1;
      #HALF;
   endtask
   // traffic is only issued while the bench holds the user drive frozen
   task frame(input logic [1:0] ins, input logic [7:0] wd);
      integer i;
      #3;
      bit_cycle(1'b1, 1'b0);
      bit_cycle(1'b1, ins[0]);
      bit_cycle(1'b1, ins[1]);
      for (i = 0; i < 8; i++) begin
         if (ins[0] === 1'b0) begin
            link_clock = 1'b0;
            host_oe = 1'b0;
            #HALF;
            rd_value[i] = pin_level;
            link_clock = 1'b1;
            #HALF;
         end else bit_cycle(1'b1, wd[i]);
      end
      bit_cycle(1'b0, 1'b0);
      if (ins[0] === 1'b0) -> rd_ev;
   endtask
endmodule

// File: verification/two_wire_debug_flash_port_tb_top.sv
/*
 * self-checking bench for the two-wire debug and flash port.
 * assumes host_adapter_model plays the host on the link.
 */
`timescale 1ns/100ps
module two_wire_debug_flash_port_tb_top;
   import debug_port_pkg::*;
   typedef struct packed {
      logic [7:0] data;
      logic cv;
      logic av;
      logic [7:0] code;
   } wr_note_type;
   logic clk;
   logic srst = 1'b1;
   logic user_pin_out = 1'b0;
   logic user_pin_oe = 1'b0;
   logic [7:0] fpd_read_value = 8'h00;
   logic flash_done = 1'b0;
   logic link_clock, pin_level, dev_out, dev_oe, rd_strobe, wr_strobe, cv, av, busy, in_frame;
   logic [7:0] wr_data, code, ctl, v;
   logic [7:0] exp_code = 8'h00;
   logic [7:0] cmds [4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE, CMD_DEVICE_ERASE};
   integer num_errors = 0;
   integer n_tests = 0;
   integer rd_pulses = 0;
   integer seed = 32'hA773F92C;
   integer i;
   wr_note_type wr_q[$];
   wr_note_type n;
   logic [7:0] rd_q[$];
   two_wire_debug_flash_port i_two_wire_debug_flash_port (.clk(clk), .srst(srst),
      .debug_link_clock(link_clock), .port_three_bit_zero_pin_in(pin_level),
      .port_three_bit_zero_pin_out(dev_out), .port_three_bit_zero_pin_oe(dev_oe),
      .user_pin_out(user_pin_out), .user_pin_oe(user_pin_oe), .fpd_read_value(fpd_read_value),
      .fpd_read_strobe(rd_strobe), .fpd_write_strobe(wr_strobe), .fpd_write_data(wr_data),
      .cmd_valid(cv), .cmd_code(code), .arg_valid(av), .flash_done(flash_done),
      .cmd_active(busy), .flash_program_control(ctl), .frame_active(in_frame));
   host_adapter_model i_host_adapter_model (.dev_out(dev_out), .dev_oe(dev_oe),
      .link_clock(link_clock), .pin_level(pin_level));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task check_bit(input logic got, input logic exp, input string what);
      check_byte({7'h00, got}, {7'h00, exp}, what);
   endtask
   task rd(input logic [1:0] ins, input logic [7:0] exp);
      rd_q.push_back(exp);
      i_host_adapter_model.frame(ins, 8'h00);
   endtask
   task wr(input logic [1:0] ins, input logic [7:0] d, input logic st, input logic c,
         input logic a);
      if (c) exp_code = d;
      if (st) wr_q.push_back('{d, c, a, exp_code});
      i_host_adapter_model.frame(ins, d);
   endtask
   // user drive changes only between frames and stays frozen in them
   task idle_pins;
      @(posedge clk);
      user_pin_out <= 1'($random(seed));
      user_pin_oe <= 1'($random(seed));
      repeat (3) @(posedge clk);
      check_bit(dev_out, user_pin_out, "pin value");
      check_bit(dev_oe, user_pin_oe, "pin enable");
      check_bit(in_frame, 1'b0, "frame idle");
   endtask
   always @(posedge clk) begin
      if (rd_strobe === 1'b1) rd_pulses++;
      if (wr_strobe === 1'b1) begin
         n = wr_q.pop_front();
         check_byte(wr_data, n.data, "write data");
         check_bit(cv, n.cv, "command flag");
         check_bit(av, n.av, "argument flag");
         check_byte(code, n.code, "command code");
      end else if (cv === 1'b1 || av === 1'b1) check_bit(1'b1, 1'b0, "stray flag");
   end
   always @(i_host_adapter_model.rd_ev)
      check_byte(i_host_adapter_model.rd_value, rd_q.pop_front(), "read byte");
   task give_verdict;
      $display("compares %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #300us;
      num_errors++;
      $display("BAD %0t run timed out", $time);
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      check_byte(ctl, CONTROL_RESET, "control at reset");
      idle_pins();
      rd(INSTR_ADDR_READ, SELECT_RESET);
      $display("test reset done");
      wr(INSTR_ADDR_WRITE, SEL_PART_IDENTITY, 1'b0, 1'b0, 1'b0);
      rd(INSTR_DATA_READ, PART_IDENTITY_DEFAULT);
      wr(INSTR_DATA_WRITE, ~PART_IDENTITY_DEFAULT, 1'b0, 1'b0, 1'b0);
      rd(INSTR_DATA_READ, PART_IDENTITY_DEFAULT);
      wr(INSTR_ADDR_WRITE, SEL_SILICON_REVISION, 1'b0, 1'b0, 1'b0);
      rd(INSTR_DATA_READ, SILICON_REVISION_DEFAULT);
      wr(INSTR_ADDR_WRITE, 8'hAC, 1'b0, 1'b0, 1'b0);
      rd(INSTR_DATA_READ, BYTE_ZERO);
      idle_pins();
      $display("test identity done");
      wr(INSTR_ADDR_WRITE, SEL_FLASH_CONTROL, 1'b0, 1'b0, 1'b0);
      v = 8'($random(seed));
      wr(INSTR_DATA_WRITE, v, 1'b0, 1'b0, 1'b0);
      rd(INSTR_DATA_READ, v);
      check_byte(ctl, v, "control port");
      $display("test control done");
      wr(INSTR_ADDR_WRITE, SEL_FLASH_DATA, 1'b0, 1'b0, 1'b0);
      for (i = 0; i < 4; i++) begin
         wr(INSTR_DATA_WRITE, cmds[i], 1'b1, 1'b1, 1'b0);
         check_bit(busy, 1'b1, "command running");
         wr(INSTR_DATA_WRITE, 8'($random(seed)), 1'b1, 1'b0, 1'b1);
         @(posedge clk);
         flash_done <= 1'b1;
         @(posedge clk);
         flash_done <= 1'b0;
         repeat (3) @(posedge clk);
         check_bit(busy, 1'b0, "command ended");
      end
      wr(INSTR_DATA_WRITE, 8'h55, 1'b1, 1'b0, 1'b0);
      fpd_read_value <= 8'($random(seed));
      @(posedge clk);
      rd(INSTR_DATA_READ, fpd_read_value);
      check_byte(8'(rd_pulses), 8'h01, "flash read strobes");
      check_byte(8'(wr_q.size()), 8'h00, "missing write strobes");
      idle_pins();
      $display("test flash data done");
      give_verdict();
   end
endmodule
